/* include/tws_defs.svh */
// Register map, field positions, reset values and counts of the three-wire serial port
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

// Register addresses
`define TWS_ADDR_MODE      16'hFFB0
`define TWS_ADDR_CLKSEL    16'hFFB1
`define TWS_ADDR_TXBUF     16'hFFB2
`define TWS_ADDR_SHIFT     16'hFFB3

// Mode register fields
`define TWS_MODE_EN        7
`define TWS_MODE_TXRX      6
`define TWS_MODE_DIR       4
`define TWS_MODE_BUSY      0
`define TWS_MODE_WMASK     8'hD0
`define TWS_MODE_RESET     8'h00

// Clock select register fields (5 stored bits, upper three read zero)
`define TWS_CLKSEL_POL     4
`define TWS_CLKSEL_PHASE   3
`define TWS_CLKSEL_SRC_HI  2
`define TWS_CLKSEL_SRC_LO  0
`define TWS_CLKSEL_RESET   5'h10
`define TWS_SRC_EXT        3'h7

// Transfer length: 8 bits, two serial clock edges per bit
`define TWS_LAST_EDGE      4'hF

`endif

/* include/tws_pkg.sv */
// Types and helper functions shared by the three-wire serial port modules
package tws_pkg;

    typedef logic [7:0] tws_byte_type;
    typedef logic [2:0] tws_src_type;

    typedef enum logic [0:0] {
        TWS_IDLE = 1'b0,
        TWS_XFER = 1'b1
    } tws_state_type;

    // Last count of a serial clock half period: fx/2^(sel+2) has half period 2^(sel+1)
    function automatic logic [7:0] tws_half_last(input tws_src_type sel);
        logic [8:0] span;
        span = 9'h002 << sel;
        return span[7:0] - 8'h01;
    endfunction

    // Bit that leaves first (or next) for the chosen direction
    function automatic logic tws_lead_bit(input tws_byte_type data, input logic lsb_first);
        return lsb_first ? data[0] : data[7];
    endfunction

endpackage

/* include/tws_div_if.sv */
// Handshake between the port controller and its serial clock divider
interface tws_div_if;
    import tws_pkg::*;

    logic        run;
    tws_src_type sel;
    logic        tick;

    modport ctrl (output run, output sel, input tick);
    modport div  (input run, input sel, output tick);
endinterface

/* hw/tws_sync.sv */
// Two-stage synchroniser for the serial clock and serial data input pins
module tws_sync (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Pin levels in and synchronised out
    input  wire logic [1:0] d,
    output logic      [1:0] q
);
    logic [1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 2'h0;
            q    <= 2'h0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

/* hw/tws_clkdiv.sv */
// Serial clock divider: one-cycle tick at each half period of the chosen rate
module tws_clkdiv (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control from the port
    tws_div_if.div    dif
);
    import tws_pkg::*;

    logic [7:0] cnt;

    assign dif.tick = dif.run && (cnt == tws_half_last(dif.sel));

    // Restart from zero so the first half period of a transfer is full length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
        end else if (!dif.run || dif.tick) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

/* hw/tws_top.sv */
// Three-wire clocked serial port: registers, transfer control and pin drive
//
// Summary of operation
// - Enable off releases pins, no transfers
// - Direction bit picks MSB or LSB first
// - Mode register at FFB0H resets to 00H
// - Mode bit 0 is read-only busy flag
// - Receive-only mode holds serial output low
// - Clearing enable clears busy, aborts transfer
// - Clock select at FFB1H resets to 10H
// - Polarity and phase bits choose type 1-4
// - Source field: fx/4 to fx/256, or external
// - Exactly eight bits, each on serial clock
// - Transmit buffer write starts duplex transfer
// - Shift register read starts receive-only transfer
// - Busy on start; done pulse, busy clear after eight
// - Phase 0: first bit out on leading edge
// - Phase 0: later bits out on leading edges
// - Phase 1: first bit out at start
// - Phase 1: later bits out on trailing edges
// - Output holds last bit after transfer
`include "tws_defs.svh"

module tws_top (
    // Clock and reset
    input  wire logic                  CORE_CLK,
    input  wire logic                  ARST_N,
    // Register access
    input  wire logic [15:0]           REG_ADDR,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    input  wire tws_pkg::tws_byte_type REG_WDATA,
    output tws_pkg::tws_byte_type      REG_RDATA,
    // Serial clock pin
    input  wire logic                  SER_CLK_PIN_IN,
    output logic                       SER_CLK_PIN_OUT,
    output logic                       SER_CLK_PIN_OE,
    // Serial data pins
    input  wire logic                  SER_IN_PIN,
    output logic                       SER_OUT_PIN,
    output logic                       SER_OUT_PIN_OE,
    // Completion event
    output logic                       XFER_DONE_IRQ
);
    import tws_pkg::*;

    // Reset release
    logic [1:0]    rst_pipe;
    logic          rst_n;

    // Software-visible state
    tws_byte_type  mode_reg;
    logic [4:0]    clock_select_reg;
    tws_byte_type  tx_buffer;
    tws_byte_type  shift_reg;

    // Transfer state
    tws_state_type state;
    tws_state_type next_state;
    logic [3:0]    edge_cnt;
    logic          ser_clk_q;

    // Synchronised pins
    logic [1:0]    pin_s;
    logic          ser_clk_s;
    logic          ser_clk_d;
    logic          ser_in_s;

    // Decoded controls
    logic          op_enable;
    logic          txrx_select;
    logic          first_bit_dir;
    logic          clk_polarity;
    logic          data_phase;
    tws_src_type   clk_src_sel;
    logic          ext_clk;
    logic          idle_lvl;
    logic          busy_flag;

    // Access strobes
    logic          wr_mode;
    logic          wr_clksel;
    logic          wr_txbuf;
    logic          rd_shift;
    logic          disable_now;
    logic          start_tx;
    logic          start_rx;
    logic          start;

    // Edge events
    logic          ext_edge;
    logic          any_edge;
    logic          lead_edge;
    logic          sample_edge;
    logic          drive_edge;
    logic          last_edge;

    tws_div_if     dif ();

    // Reset asserts at once and releases in step with the clock
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe[1];

    tws_sync u_sync (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .d     ({SER_CLK_PIN_IN, SER_IN_PIN}),
        .q     (pin_s)
    );

    assign ser_clk_s = pin_s[1];
    assign ser_in_s  = pin_s[0];

    tws_clkdiv u_div (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .dif   (dif)
    );

    // Field decode
    assign op_enable     = mode_reg[`TWS_MODE_EN];
    assign txrx_select   = mode_reg[`TWS_MODE_TXRX];
    assign first_bit_dir = mode_reg[`TWS_MODE_DIR];
    assign clk_polarity  = clock_select_reg[`TWS_CLKSEL_POL];
    assign data_phase    = clock_select_reg[`TWS_CLKSEL_PHASE];
    assign clk_src_sel   = clock_select_reg[`TWS_CLKSEL_SRC_HI:`TWS_CLKSEL_SRC_LO];
    assign ext_clk       = (clk_src_sel == `TWS_SRC_EXT);
    assign idle_lvl      = ~clk_polarity;
    assign busy_flag     = (state == TWS_XFER);

    // Access decode
    assign wr_mode     = REG_WR && (REG_ADDR == `TWS_ADDR_MODE);
    assign wr_clksel   = REG_WR && (REG_ADDR == `TWS_ADDR_CLKSEL);
    assign wr_txbuf    = REG_WR && (REG_ADDR == `TWS_ADDR_TXBUF);
    assign rd_shift    = REG_RD && (REG_ADDR == `TWS_ADDR_SHIFT);
    assign disable_now = wr_mode && !REG_WDATA[`TWS_MODE_EN];

    // A start needs the port enabled and idle; requests while busy are dropped
    assign start_tx = wr_txbuf && op_enable && txrx_select && !busy_flag;
    assign start_rx = rd_shift && op_enable && !txrx_select && !busy_flag;
    assign start    = start_tx || start_rx;

    // The divider only runs while the port makes its own clock
    assign dif.run = busy_flag && !ext_clk;
    assign dif.sel = clk_src_sel;

    // Edge detection reads only the second synchroniser stage and its delayed copy
    assign ext_edge  = ext_clk && (ser_clk_s != ser_clk_d);
    assign any_edge  = busy_flag && (ext_clk ? ext_edge : dif.tick);
    assign lead_edge = ext_clk ? (ser_clk_d == idle_lvl) : (ser_clk_q == idle_lvl);

    // Phase 0 samples on trailing edges, phase 1 on leading edges
    assign sample_edge = any_edge && (lead_edge == data_phase);
    assign drive_edge  = any_edge && (lead_edge != data_phase);
    assign last_edge   = any_edge && (edge_cnt == `TWS_LAST_EDGE);

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ser_clk_d <= 1'b0;
        end else begin
            ser_clk_d <= ser_clk_s;
        end
    end

    // Mode register; bit 5 and bits 3 to 0, including the busy position, are not stored
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= `TWS_MODE_RESET;
        end else if (wr_mode) begin
            mode_reg <= REG_WDATA & `TWS_MODE_WMASK;
        end
    end

    // Clock select register; writes are accepted at any time
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            clock_select_reg <= `TWS_CLKSEL_RESET;
        end else if (wr_clksel) begin
            clock_select_reg <= REG_WDATA[4:0];
        end
    end

    // Transmit buffer keeps its value while busy so the word in flight is stable
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_buffer <= 8'h00;
        end else if (wr_txbuf && !busy_flag) begin
            tx_buffer <= REG_WDATA;
        end
    end

    // Transfer sequencing
    always_comb begin
        next_state = state;
        case (state)
            TWS_IDLE: begin
                if (start) begin
                    next_state = TWS_XFER;
                end
            end
            TWS_XFER: begin
                if (last_edge) begin
                    next_state = TWS_IDLE;
                end
            end
            default: begin
                next_state = TWS_IDLE;
            end
        endcase
        if (!op_enable || disable_now) begin
            next_state = TWS_IDLE;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= TWS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt <= 4'h0;
        end else if (start) begin
            edge_cnt <= 4'h0;
        end else if (any_edge) begin
            edge_cnt <= edge_cnt + 4'h1;
        end
    end

    // Shift register: loaded with the written byte at a duplex start, shifts in on each sample edge
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 8'h00;
        end else if (start_tx) begin
            shift_reg <= REG_WDATA;
        end else if (sample_edge) begin
            if (first_bit_dir) begin
                shift_reg <= {ser_in_s, shift_reg[7:1]};
            end else begin
                shift_reg <= {shift_reg[6:0], ser_in_s};
            end
        end
    end

    // Output latch; it is left alone between transfers so the last bit stays on the pin
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            SER_OUT_PIN <= 1'b0;
        end else if (!txrx_select) begin
            SER_OUT_PIN <= 1'b0;
        end else if (start_tx && data_phase) begin
            SER_OUT_PIN <= tws_lead_bit(REG_WDATA, first_bit_dir);
        end else if (drive_edge && !last_edge) begin
            SER_OUT_PIN <= tws_lead_bit(shift_reg, first_bit_dir);
        end
    end

    // Internal serial clock: parks at its idle level, toggles each half period when busy
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ser_clk_q <= 1'b0;
        end else if (!busy_flag) begin
            ser_clk_q <= idle_lvl;
        end else if (dif.tick) begin
            ser_clk_q <= ~ser_clk_q;
        end
    end

    // Pin drive; both driven pins, serial clock and serial output, are released while the port is disabled
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            SER_CLK_PIN_OUT <= 1'b0;
            SER_CLK_PIN_OE  <= 1'b0;
            SER_OUT_PIN_OE  <= 1'b0;
        end else begin
            SER_CLK_PIN_OUT <= ser_clk_q;
            SER_CLK_PIN_OE  <= op_enable && !ext_clk;
            SER_OUT_PIN_OE  <= op_enable;
        end
    end

    // Completion pulse; an aborted transfer raises none
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            XFER_DONE_IRQ <= 1'b0;
        end else begin
            XFER_DONE_IRQ <= last_edge && op_enable && !disable_now;
        end
    end

    // Read data, one cycle after the read strobe; unmapped addresses read zero
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `TWS_ADDR_MODE: begin
                    REG_RDATA <= {mode_reg[7:1], busy_flag};
                end
                `TWS_ADDR_CLKSEL: begin
                    REG_RDATA <= {3'h0, clock_select_reg};
                end
                `TWS_ADDR_TXBUF: begin
                    REG_RDATA <= tx_buffer;
                end
                `TWS_ADDR_SHIFT: begin
                    REG_RDATA <= shift_reg;
                end
                default: begin
                    REG_RDATA <= 8'h00;
                end
            endcase
        end
    end

endmodule

/* verification/tws_top_sva.sv */
// Concurrent checks on the pins of the three-wire serial port
module tws_top_sva (
    // Clock and reset
    input wire logic                  CORE_CLK,
    input wire logic                  ARST_N,
    // Register access
    input wire logic [15:0]           REG_ADDR,
    input wire logic                  REG_WR,
    input wire logic                  REG_RD,
    input wire tws_pkg::tws_byte_type REG_WDATA,
    input wire tws_pkg::tws_byte_type REG_RDATA,
    // Serial pins and completion
    input wire logic                  SER_CLK_PIN_OUT,
    input wire logic                  SER_CLK_PIN_OE,
    input wire logic                  SER_OUT_PIN,
    input wire logic                  SER_OUT_PIN_OE,
    input wire logic                  XFER_DONE_IRQ
);
    import tws_pkg::*;
    logic       en, trx, dir, pol, bsq, bsy, wm, st;
    logic [2:0] src;
    logic [2:0] idl;
    logic [4:0] tg;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    assign bsy = bsq && !XFER_DONE_IRQ;
    assign wm  = REG_WR && REG_ADDR == 16'hFFB0;
    assign st  = !bsy && en && (REG_WR && REG_ADDR == 16'hFFB2 && trx || REG_RD && REG_ADDR == 16'hFFB3 && !trx);
    // Shadow copies of the mode and clock select settings
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            {en, trx, dir, pol, src} <= 7'h08;
        end else begin
            if (wm) {en, trx, dir} <= {REG_WDATA[7:6], REG_WDATA[4]};
            if (REG_WR && REG_ADDR == 16'hFFB1) {pol, src} <= {REG_WDATA[4], REG_WDATA[2:0]};
        end
    end
    // Busy tracking, clock toggles per transfer, idle time
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            {bsq, tg, idl} <= 9'h000;
        end else begin
            bsq <= st || bsq && !XFER_DONE_IRQ && !(wm && !REG_WDATA[7]);
            tg  <= st ? 5'h00 : tg + 5'($changed(SER_CLK_PIN_OUT));
            idl <= (bsy || wm || REG_WR && REG_ADDR == 16'hFFB1) ? 3'h0 : idl + 3'(idl != 3'h7);
        end
    end
    property p_irq_pulse;
        XFER_DONE_IRQ |=> !XFER_DONE_IRQ;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("done pulse longer than one cycle");
    property p_mode_rd;
        REG_RD && REG_ADDR == 16'hFFB0 |=> REG_RDATA == {$past(en), $past(trx), 1'b0, $past(dir), 3'h0, $past(bsy)};
    endproperty
    a_mode_rd: assert property (p_mode_rd)
        else $error("mode register read wrong");
    property p_unmapped;
        REG_RD && REG_ADDR[15:2] != 14'h3FEC |=> REG_RDATA == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_abort;
        wm && !REG_WDATA[7] |=> !XFER_DONE_IRQ [*8];
    endproperty
    a_abort: assert property (p_abort)
        else $error("done after disable");
    property p_rx_low;
        !trx && !$past(trx) |-> !SER_OUT_PIN;
    endproperty
    a_rx_low: assert property (p_rx_low)
        else $error("output not low in receive mode");
    property p_off_pins;
        !en && !$past(en) |-> !SER_OUT_PIN_OE && !SER_CLK_PIN_OE;
    endproperty
    a_off_pins: assert property (p_off_pins)
        else $error("pins driven while disabled");
    property p_on_pins;
        en && $past(en) |-> SER_OUT_PIN_OE && SER_CLK_PIN_OE == (src != 3'h7);
    endproperty
    a_on_pins: assert property (p_on_pins)
        else $error("pin enables wrong while enabled");
    property p_idle_clk;
        idl == 3'h7 && src != 3'h7 |-> SER_CLK_PIN_OUT == !pol;
    endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("serial clock not at idle level");
    property p_eight;
        XFER_DONE_IRQ && src != 3'h7 |-> ##4 tg == 5'h10;
    endproperty
    a_eight: assert property (p_eight)
        else $error("serial clock edge count wrong");
    c_duplex: cover property (XFER_DONE_IRQ && trx);
    c_rxonly: cover property (XFER_DONE_IRQ && !trx);
    c_abort: cover property (wm && !REG_WDATA[7] && bsy);
endmodule

/* verification/tws_periph.sv */
// Behavioural peripheral on the serial lines: swaps a byte, can supply the clock
module tws_periph (
    // Clock for the supplied serial clock
    input  wire logic       clk,
    // Link settings
    input  wire logic       pol,
    input  wire logic       pha,
    input  wire logic       lsb,
    // Serial lines
    input  wire logic       sclk,
    input  wire logic       mosi,
    output logic            miso,
    output logic            ext_clk,
    // Byte collected from the port
    output logic      [7:0] rx
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh = 8'h00;
    int         n = 8;
    initial begin
        miso = 1'b0;
        ext_clk = 1'b0;
        rx = 8'h00;
    end
    // Idle level settles first so its own edge is not taken as a bit
    task automatic prep(input logic [7:0] d);
        ext_clk = ~pol;
        #1;
        sh = d;
        n = 0;
        rx = 8'h00;
        miso = lsb ? d[0] : d[7];
    endtask
    task automatic run(input int half);
        repeat (16) begin
            repeat (half) @(posedge clk);
            #1;
            ext_clk = ~ext_clk;
        end
    endtask
    always @(sclk) begin
        if ((sclk === pol) == pha && n < 8) begin
            rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            n++;
        end else if (n > 0 && n < 8) begin
            sh = lsb ? sh >> 1 : sh << 1;
            miso = lsb ? sh[0] : sh[7];
        end
    end
endmodule

/* verification/tws_top_tb.sv */
// Self-checking bench for the three-wire serial port
module tws_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tws_pkg::*;
    logic         clk, arst_n, wr, rd, sck_out, sck_oe, sck, pclk, sin, sout, sout_oe, irq;
    logic         pol, pha, dir;
    logic [15:0]  addr;
    tws_byte_type wdata, rdata, prx;
    int           fails = 0;
    int           checked = 0;
    int           cyc = 0;
    tws_top i_tws_top (.CORE_CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .SER_CLK_PIN_IN(sck), .SER_CLK_PIN_OUT(sck_out),
        .SER_CLK_PIN_OE(sck_oe), .SER_IN_PIN(sin), .SER_OUT_PIN(sout), .SER_OUT_PIN_OE(sout_oe),
        .XFER_DONE_IRQ(irq));
    // A released output line shows the inverse of its last level
    tws_periph i_tws_periph (.clk(clk), .pol(pol), .pha(pha), .lsb(dir), .sclk(sck),
        .mosi(sout_oe ? sout : ~sout), .miso(sin), .ext_clk(pclk), .rx(prx));
    assign sck = sck_oe ? sck_out : pclk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input tws_byte_type got, input tws_byte_type exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic [15:0] a, input tws_byte_type d, input logic w);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(posedge clk);
        #1;
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic rck(input string what, input logic [15:0] a, input tws_byte_type exp);
        acc(a, 8'h00, 1'b0);
        chk(what, rdata, exp);
    endtask
    task automatic wait_cyc(input int n, input logic until_irq, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < n && !(until_irq && seen); i++) begin
            @(posedge clk);
            #1;
            seen = seen | (irq === 1'b1);
        end
    endtask
    task automatic meas(output tws_byte_type n);
        logic v;
        n = 8'h00;
        for (int i = 0; i < 600 && sck_out === sck_out; i++) begin
            v = sck_out;
            @(posedge clk);
            #1;
            if (sck_out !== v) break;
        end
        v = sck_out;
        while (sck_out === v && n != 8'hFF) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        tws_byte_type t, h;
        logic [2:0] src;
        logic seen;
        {arst_n, wr, rd, pol, pha, dir, addr, wdata} = {6'h04, 16'h0000, 8'h00};
        repeat (20) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge clk);
        rck("mode reset", 16'hFFB0, 8'h00);
        rck("clock select reset", 16'hFFB1, 8'h10);
        rck("unmapped", 16'hFFB4, 8'h00);
        acc(16'hFFB0, 8'h01, 1'b1);
        rck("busy write", 16'hFFB0, 8'h00);
        $display("test registers finished");
        for (int i = 0; i < 8; i++) begin
            {src, pol, pha, dir} = {(i == 7) ? 3'h2 : 3'(i), i[1], i[0], i[2]};
            t = 8'h5A ^ (8'h25 * 8'(i));
            acc(16'hFFB1, {3'h0, pol, pha, src}, 1'b1);
            rck("clock select", 16'hFFB1, {3'h0, pol, pha, src});
            acc(16'hFFB0, {2'h3, 1'b0, dir, 4'h0}, 1'b1);
            i_tws_periph.prep(~t);
            acc(16'hFFB2, t, 1'b1);
            wait_cyc(1, 1'b0, seen);
            if (pha) chk("first bit", {7'h00, sout}, {7'h00, dir ? t[0] : t[7]});
            meas(h);
            chk("half period", h, 8'h02 << src);
            rck("busy", 16'hFFB0, {2'h3, 1'b0, dir, 4'h1});
            wait_cyc(5000, 1'b1, seen);
            chk("done", {7'h00, seen}, 8'h01);
            wait_cyc(5, 1'b0, seen);
            chk("sent", prx, t);
            chk("last bit", {7'h00, sout}, {7'h00, dir ? t[7] : t[0]});
            if (src != 3'h0) rck("received", 16'hFFB3, ~t);
            rck("tx buffer", 16'hFFB2, t);
            acc(16'hFFB0, 8'h00, 1'b1);
        end
        $display("test duplex types finished");
        {pol, pha, dir} = 3'h4;
        acc(16'hFFB1, 8'h12, 1'b1);
        acc(16'hFFB0, 8'h80, 1'b1);
        i_tws_periph.prep(8'hC3);
        acc(16'hFFB3, 8'h00, 1'b0);
        wait_cyc(5000, 1'b1, seen);
        chk("receive done", {7'h00, seen}, 8'h01);
        wait_cyc(5, 1'b0, seen);
        chk("receive output", {7'h00, sout}, 8'h00);
        rck("receive data", 16'hFFB3, 8'hC3);
        wait_cyc(20, 1'b0, seen);
        acc(16'hFFB0, 8'h00, 1'b1);
        rck("abort busy", 16'hFFB0, 8'h00);
        wait_cyc(300, 1'b0, seen);
        chk("abort done", {7'h00, seen}, 8'h00);
        chk("pins off", {6'h00, sck_oe, sout_oe}, 8'h00);
        $display("test receive and abort finished");
        acc(16'hFFB1, 8'h17, 1'b1);
        acc(16'hFFB0, 8'hC0, 1'b1);
        i_tws_periph.prep(8'h69);
        acc(16'hFFB2, 8'h3C, 1'b1);
        i_tws_periph.run(8);
        wait_cyc(100, 1'b1, seen);
        chk("ext done", {7'h00, seen}, 8'h01);
        wait_cyc(5, 1'b0, seen);
        chk("ext sent", prx, 8'h3C);
        rck("ext received", 16'hFFB3, 8'h69);
        chk("ext clock pin", {7'h00, sck_oe}, 8'h00);
        $display("test external clock finished");
        conclude();
    end
endmodule
bind tws_top tws_top_sva i_tws_top_sva (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .SER_CLK_PIN_OUT(SER_CLK_PIN_OUT), .SER_CLK_PIN_OE(SER_CLK_PIN_OE), .SER_OUT_PIN(SER_OUT_PIN),
    .SER_OUT_PIN_OE(SER_OUT_PIN_OE), .XFER_DONE_IRQ(XFER_DONE_IRQ));
